// [rtc_pkg.sv]
// constants for the clock trim, alarm, watchdog and interrupt block
package rtc_pkg;
    localparam int unsigned REF_HZ = 10_000_000;
    localparam int unsigned ADDR_W = 17;
    localparam logic [16:0] A_FLAGS = 17'h1FFF0;
    localparam logic [16:0] A_ALM_LO = 17'h1FFF1;
    localparam logic [16:0] A_ALM_SEC = 17'h1FFF2;
    localparam logic [16:0] A_ALM_DATE = 17'h1FFF5;
    localparam logic [16:0] A_IRQ = 17'h1FFF6;
    localparam logic [16:0] A_WDOG = 17'h1FFF7;
    localparam logic [16:0] A_TRIM = 17'h1FFF8;
    // event flags bits
    localparam int F_WDF = 7;
    localparam int F_AF = 6;
    localparam int F_PF = 5;
    localparam int F_OSCILLATOR_FAIL_FLAG = 4;
    localparam int F_CAL = 2;
    localparam int F_WH = 1;
    localparam int F_RD = 0;
    // irq control bits
    localparam int I_WIE = 7;
    localparam int I_AIE = 6;
    localparam int I_PFE = 5;
    localparam int I_HL = 4;
    localparam int I_PL = 3;
    // watchdog control bits
    localparam int W_STB = 7;
    localparam int W_LOCK = 6;
    // clock trim bits and alarm match bit
    localparam int T_SIGN = 5;
    localparam int ALM_MATCH = 7;
    // oscillator divider chain
    localparam logic [15:0] OSC_PER_SEC = 16'h8000;
    localparam logic [15:0] TRIM_SHORT = 16'h0080;
    localparam logic [15:0] TRIM_LONG = 16'h0100;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] MIN_LAST = 6'h3F;
    localparam logic [9:0] DIV32_LAST = 10'h3FF;
    localparam logic [4:0] TEST_HALF = 5'h1F;
    // interrupt pulse
    localparam int unsigned PULSE_MS = 200;
    localparam int unsigned PULSE_CYC = PULSE_MS * (REF_HZ / 1000);
    localparam int unsigned PULSE_W = 21;
    typedef enum logic [2:0] {
        PS_IDLE = 3'h1,
        PS_PULSE = 3'h2,
        PS_HOLD = 3'h4
    } rtc_pulse_t;
endpackage

// [rtc_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rtc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            q <= '0;
        end
        else
        begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule

// [rtc_alarm_cmp.sv]
// alarm field comparator with per-field match bits
`timescale 1ns/10ps
module rtc_alarm_cmp (
    input wire logic [31:0] alarm,
    input wire logic [31:0] now,
    output logic hit
);
    logic [3:0] skip;
    logic [3:0] ok;

    for (genvar i = 0; i < 4; i++)
    begin : g_fld
        assign skip[i] = alarm[8*i+rtc_pkg::ALM_MATCH];
        assign ok[i] = skip[i] || (alarm[8*i +: 7] == now[8*i +: 7]);
    end

    // all fields masked means alarm off
    assign hit = !(&skip) && (&ok);
endmodule

// [rtc_trim_alarm_wdog.sv]
// clock trim, alarm, watchdog, power monitor and interrupt pin logic
// Overview of operation
// - five-bit trim magnitude, bit five is sign
// - trim acts within repeating sixty-four minute cycle
// - magnitude N modifies first 2N minutes
// - trim-test bit toggles pin at 512 Hz
// - test frequency ignores trim register value
// - alarm match sets flag and optional interrupt
// - per-field match bits; all ones disables alarm
// - flags read clears all event flags except oscillator-fail
// - alarm settings apply when write-hold clears
// - watchdog counts down on 32 Hz tick
// - watchdog loads at power-up, reloads on strobe
// - watchdog reaching zero sets flag, optional interrupt
// - timeout writes ignored when the written lock bit is set
// - zero timeout disables the watchdog
// - backup supply blocks host access, clock continues
// - outside trim-test, pin asserts only for enabled raised flag
// - pulse mode drives pin about 200 ms
// - level mode holds pin until flags read
// - no interrupts while on backup supply
// - polarity bit: high push-pull or low open-drain
// - flags read ends pulse early
// - all flags reset to zero, oscillator-fail included
`timescale 1ns/10ps
module rtc_trim_alarm_wdog #(
    parameter int unsigned PULSE_CYC = rtc_pkg::PULSE_CYC,
    parameter logic [5:0] WDOG_INIT = 6'h00
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic osc_in,
    input wire logic vcc_low,
    input wire logic osc_fail_det,
    input wire logic [7:0] cur_seconds,
    input wire logic [7:0] cur_minutes,
    input wire logic [7:0] cur_hours,
    input wire logic [7:0] cur_date,
    input wire logic [16:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic sec_tick,
    output logic int_o,
    output logic int_oe
);
    // ==========================================================
    // reset release and pin synchronisers
    logic rst_s1_r;
    logic rst_n_r;
    logic [2:0] sync_q;
    logic osc_s;
    logic backup;
    logic fail_s;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    rtc_sync #(.W(3)) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n_r),
        .d({osc_in, vcc_low, osc_fail_det}),
        .q(sync_q)
    );
    assign {osc_s, backup, fail_s} = sync_q;

    // ==========================================================
    // register bus decode
    logic wr_ok;
    logic rd_ok;
    logic flags_rd;
    logic flags_wr;
    logic alm_sel;
    logic [2:0] alm_idx;

    assign wr_ok = wr && !backup;
    assign rd_ok = rd && !backup;
    assign flags_rd = rd_ok && (addr == rtc_pkg::A_FLAGS);
    assign flags_wr = wr_ok && (addr == rtc_pkg::A_FLAGS);
    assign alm_sel = (addr >= rtc_pkg::A_ALM_LO) && (addr <= rtc_pkg::A_ALM_DATE);
    assign alm_idx = addr[2:0] - 3'h1;

    // ==========================================================
    // trimmed oscillator divider
    logic osc_d_r;
    logic osc_rise;
    logic [15:0] div_cnt_r;
    logic [5:0] sec_cnt_r;
    logic [5:0] min_cnt_r;
    logic [5:0] trim_r;
    logic trim_adj;
    logic [15:0] sec_len;
    logic sec_end;
    logic tick32;

    assign osc_rise = osc_s && !osc_d_r;
    // first 2N minutes, on the first second of each
    assign trim_adj = (sec_cnt_r == 6'h00) && ({1'b0, min_cnt_r} < {trim_r[4:0], 1'b0});
    always_comb
    begin
        sec_len = rtc_pkg::OSC_PER_SEC;
        if (trim_adj && trim_r[rtc_pkg::T_SIGN])
            sec_len = rtc_pkg::OSC_PER_SEC - rtc_pkg::TRIM_SHORT;
        else if (trim_adj)
            sec_len = rtc_pkg::OSC_PER_SEC + rtc_pkg::TRIM_LONG;
    end
    assign sec_end = osc_rise && (div_cnt_r == sec_len - 16'h0001);
    assign tick32 = osc_rise && (div_cnt_r[9:0] == rtc_pkg::DIV32_LAST);

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            osc_d_r <= 1'b0;
            div_cnt_r <= 16'h0000;
            sec_cnt_r <= 6'h00;
            min_cnt_r <= 6'h00;
            sec_tick <= 1'b0;
        end
        else
        begin
            osc_d_r <= osc_s;
            sec_tick <= sec_end;
            if (sec_end)
            begin
                div_cnt_r <= 16'h0000;
                if (sec_cnt_r == rtc_pkg::SEC_LAST)
                begin
                    sec_cnt_r <= 6'h00;
                    min_cnt_r <= min_cnt_r + 6'h01;
                end
                else
                    sec_cnt_r <= sec_cnt_r + 6'h01;
            end
            else if (osc_rise)
                div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ==========================================================
    // 512 Hz test square, apart from the trimmed chain
    logic [4:0] test_cnt_r;
    logic sq_r;

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            test_cnt_r <= 5'h00;
            sq_r <= 1'b0;
        end
        else if (osc_rise)
        begin
            test_cnt_r <= test_cnt_r + 5'h01;
            if (test_cnt_r == rtc_pkg::TEST_HALF)
                sq_r <= !sq_r;
        end
    end

    // ==========================================================
    // control registers
    logic [7:0] irq_r;
    logic cal_r;
    logic wh_r;
    logic rdh_r;
    logic wd_lock_r;
    logic [5:0] wd_tmo_r;
    logic [5:0] wd_tmo_nxt;
    logic wd_wr;
    logic [4:0][7:0] alm_stg_r;
    logic [3:0][7:0] alm_act_r;

    assign wd_wr = wr_ok && (addr == rtc_pkg::A_WDOG);
    assign wd_tmo_nxt = (wd_wr && !wdata[rtc_pkg::W_LOCK]) ? wdata[5:0] : wd_tmo_r;

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            irq_r <= 8'h00;
            cal_r <= 1'b0;
            wh_r <= 1'b0;
            rdh_r <= 1'b0;
            wd_lock_r <= 1'b0;
            wd_tmo_r <= WDOG_INIT;
            trim_r <= 6'h00;
            alm_stg_r <= '0;
            alm_act_r <= '0;
        end
        else
        begin
            wd_tmo_r <= wd_tmo_nxt;
            if (flags_wr)
            begin
                wh_r <= wdata[rtc_pkg::F_WH];
                rdh_r <= wdata[rtc_pkg::F_RD];
                if (wh_r)
                    cal_r <= wdata[rtc_pkg::F_CAL];
                if (wh_r && !wdata[rtc_pkg::F_WH])
                    alm_act_r <= alm_stg_r[4:1];
            end
            if (wr_ok && alm_sel)
                alm_stg_r[alm_idx] <= wdata;
            if (wr_ok && (addr == rtc_pkg::A_IRQ))
                irq_r <= wdata;
            if (wd_wr)
                wd_lock_r <= wdata[rtc_pkg::W_LOCK];
            if (wr_ok && (addr == rtc_pkg::A_TRIM))
                trim_r <= wdata[5:0];
        end
    end

    // ==========================================================
    // alarm
    logic alm_hit;
    logic [7:0] sec_prev_r;
    logic alarm_ev;

    rtc_alarm_cmp u_alarm (
        .alarm({alm_act_r[3], alm_act_r[2], alm_act_r[1], alm_act_r[0]}),
        .now({cur_date, cur_hours, cur_minutes, cur_seconds}),
        .hit(alm_hit)
    );
    // one event per new second while matching
    assign alarm_ev = alm_hit && (cur_seconds != sec_prev_r) && !backup;

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            sec_prev_r <= 8'h00;
        else
            sec_prev_r <= cur_seconds;
    end

    // ==========================================================
    // watchdog
    logic [5:0] wd_cnt_r;
    logic wd_load_r;
    logic wd_reload;
    logic wd_expire;

    assign wd_reload = wd_load_r || (wd_wr && wdata[rtc_pkg::W_STB]);
    assign wd_expire = tick32 && !wd_reload && (wd_tmo_r != 6'h00)
        && (wd_cnt_r <= 6'h01);

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            wd_cnt_r <= 6'h00;
            wd_load_r <= 1'b1;
        end
        else
        begin
            wd_load_r <= 1'b0;
            if (wd_reload)
                wd_cnt_r <= wd_tmo_nxt;
            else if (wd_expire)
                wd_cnt_r <= wd_tmo_r;
            else if (tick32 && (wd_tmo_r != 6'h00))
                wd_cnt_r <= wd_cnt_r - 6'h01;
        end
    end

    // ==========================================================
    // event flags, set wins over the read clear
    logic wdf_r;
    logic af_r;
    logic pf_r;
    logic oscillator_fail_flag_r;
    logic backup_d_r;
    logic pf_ev;

    assign pf_ev = backup && !backup_d_r;

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            wdf_r <= 1'b0;
            af_r <= 1'b0;
            pf_r <= 1'b0;
            oscillator_fail_flag_r <= 1'b0;
            backup_d_r <= 1'b0;
        end
        else
        begin
            backup_d_r <= backup;
            wdf_r <= wd_expire || (wdf_r && !flags_rd);
            af_r <= alarm_ev || (af_r && !flags_rd);
            pf_r <= pf_ev || (pf_r && !flags_rd);
            // oscillator-fail latches on its detector, cleared only by a write
            if (fail_s)
                oscillator_fail_flag_r <= 1'b1;
            else if (flags_wr && wh_r && !wdata[rtc_pkg::F_OSCILLATOR_FAIL_FLAG])
                oscillator_fail_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // read data, valid one cycle after the strobe
    logic [7:0] flags_val;

    assign flags_val = {wdf_r, af_r, pf_r, oscillator_fail_flag_r, 1'b0, cal_r, wh_r, rdh_r};

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            rdata <= 8'h00;
        else if (!rd_ok)
            rdata <= 8'h00;
        else if (addr == rtc_pkg::A_FLAGS)
            rdata <= flags_val;
        else if (alm_sel)
            rdata <= alm_stg_r[alm_idx];
        else if (addr == rtc_pkg::A_IRQ)
            rdata <= irq_r;
        else if (addr == rtc_pkg::A_WDOG)
            rdata <= {1'b0, wd_lock_r, wd_tmo_r};
        else if (addr == rtc_pkg::A_TRIM)
            rdata <= {2'b00, trim_r};
        else
            rdata <= 8'h00;
    end

    // ==========================================================
    // interrupt pin driver
    rtc_pkg::rtc_pulse_t ps_r;
    logic [rtc_pkg::PULSE_W-1:0] pulse_cnt_r;
    logic irq_cond;
    logic pin_act;

    assign irq_cond = !backup && ((wdf_r && irq_r[rtc_pkg::I_WIE])
        || (af_r && irq_r[rtc_pkg::I_AIE])
        || (pf_r && irq_r[rtc_pkg::I_PFE]));

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ps_r <= rtc_pkg::PS_IDLE;
            pulse_cnt_r <= '0;
        end
        else
        begin
            case (ps_r)
                rtc_pkg::PS_IDLE:
                begin
                    pulse_cnt_r <= '0;
                    if (irq_cond && irq_r[rtc_pkg::I_PL])
                        ps_r <= rtc_pkg::PS_PULSE;
                end
                rtc_pkg::PS_PULSE:
                begin
                    pulse_cnt_r <= pulse_cnt_r + rtc_pkg::PULSE_W'(1);
                    if (flags_rd)
                        ps_r <= rtc_pkg::PS_HOLD;
                    else if (pulse_cnt_r == rtc_pkg::PULSE_W'(PULSE_CYC - 1))
                        ps_r <= rtc_pkg::PS_HOLD;
                end
                rtc_pkg::PS_HOLD:
                begin
                    if (!irq_cond)
                        ps_r <= rtc_pkg::PS_IDLE;
                end
                default:
                    ps_r <= rtc_pkg::PS_IDLE;
            endcase
        end
    end

    always_comb
    begin
        if (cal_r)
            pin_act = sq_r;
        else if (irq_r[rtc_pkg::I_PL])
            pin_act = (ps_r == rtc_pkg::PS_PULSE);
        else
            pin_act = irq_cond;
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            int_o <= 1'b0;
            int_oe <= 1'b0;
        end
        else if (backup)
        begin
            int_o <= 1'b0;
            int_oe <= 1'b0;
        end
        else if (irq_r[rtc_pkg::I_HL])
        begin
            int_o <= pin_act;
            int_oe <= 1'b1;
        end
        else
        begin
            int_o <= 1'b0;
            int_oe <= pin_act;
        end
    end

    // ==========================================================
    // checks
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n_r);

    property p_trim_sign;
        trim_adj && trim_r[rtc_pkg::T_SIGN] |-> sec_len == 16'h7F80;
    endproperty
    a_trim_sign: assert property (p_trim_sign) else $error("positive trim length wrong");

    property p_trim_win;
        (sec_cnt_r != 6'h00) || ({1'b0, min_cnt_r} >= {trim_r[4:0], 1'b0}) |-> sec_len == 16'h8000;
    endproperty
    a_trim_win: assert property (p_trim_win) else $error("trim outside window");

    property p_test_toggle;
        osc_rise && test_cnt_r == 5'h1F |=> sq_r != $past(sq_r);
    endproperty
    a_test_toggle: assert property (p_test_toggle) else $error("test square missed");

    property p_alarm_set;
        alarm_ev |=> af_r;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

    property p_rd_clear;
        flags_rd && !alarm_ev && !wd_expire && !pf_ev |=> !af_r && !wdf_r && !pf_r;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared");

    property p_hold_alarm;
        !(flags_wr && wh_r && !wdata[rtc_pkg::F_WH]) |=> $stable(alm_act_r);
    endproperty
    a_hold_alarm: assert property (p_hold_alarm) else $error("alarm applied early");

    property p_wd_lock;
        wd_wr && wdata[rtc_pkg::W_LOCK] |=> wd_tmo_r == $past(wd_tmo_r);
    endproperty
    a_wd_lock: assert property (p_wd_lock) else $error("locked timeout changed");

    property p_wd_flag;
        wd_expire |=> wdf_r;
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag missing");

    property p_wd_off;
        wd_tmo_r == 6'h00 |=> !$rose(wdf_r);
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired");

    // pin must be back at its inactive level two edges after the read
    property p_pulse_end;
        ps_r == rtc_pkg::PS_PULSE && flags_rd && !cal_r |=> ps_r == rtc_pkg::PS_HOLD
            ##1 ($past(irq_r[rtc_pkg::I_HL]) ? !int_o : !int_oe);
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse not ended by read");

    property p_backup_quiet;
        backup |=> !int_oe && !int_o;
    endproperty
    a_backup_quiet: assert property (p_backup_quiet) else $error("pin driven in backup");
endmodule

// [rtc_host.sv]
// host side model: register bus master and interrupt line with pull-up
`timescale 1ns/10ps
module rtc_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic int_o,
    input wire logic int_oe,
    output logic [16:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    output logic pin
);
    // open-drain line floats to the pull-up level when released
    assign pin = int_oe ? int_o : 1'b1;
    initial
    begin
        addr = 17'h00000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic put(input logic [16:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic get(input logic [16:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

// [tb_rtc_trim_alarm_wdog.sv]
// testbench for the trim, alarm, watchdog and interrupt block
`timescale 1ns/10ps
module tb_rtc_trim_alarm_wdog;
    localparam int PULSE = 20;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic osc_in = 1'b0;
    logic vcc_low = 1'b0;
    logic osc_fail = 1'b0;
    logic [7:0] cur_seconds = 8'h00;
    logic [7:0] cur_date = 8'h01;
    logic [1:0] osc_div = 2'h0;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic int_o;
    logic int_oe;
    logic pin;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    // ==========================================
    // clocks and design
    always #50 ref_clk = ~ref_clk;
    // fast oscillator stand-in so watchdog ticks fit the run
    always @(posedge ref_clk)
    begin
        osc_div <= osc_div + 2'h1;
        osc_in <= osc_div[1];
    end
    rtc_trim_alarm_wdog #(.PULSE_CYC(PULSE), .WDOG_INIT(6'h00)) rtc_trim_alarm_wdog_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .osc_in(osc_in), .vcc_low(vcc_low),
        .osc_fail_det(osc_fail), .cur_seconds(cur_seconds), .cur_minutes(8'h00),
        .cur_hours(8'h00), .cur_date(cur_date), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sec_tick(), .int_o(int_o), .int_oe(int_oe));
    rtc_host rtc_host_inst (.clk(ref_clk), .rdata(rdata), .int_o(int_o), .int_oe(int_oe),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .pin(pin));
    // ==========================================
    // shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [16:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rtc_host_inst.get(a, d);
        check(d, exp);
    endtask
    task automatic pins(input logic [1:0] exp);
        #1;
        check({6'h00, int_oe, int_o}, {6'h00, exp});
    endtask
    task automatic wait_pin(input logic lvl, input int limit);
        int i;
        for (i = 0; i < limit && int_o !== lvl; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        if (int_o !== lvl)
        begin
            bad_count++;
            $display("unexpected at %0t: interrupt line wait ran out", $time);
            conclude();
        end
    endtask
    task automatic toggles(output int cnt);
        logic last;
        last = int_o;
        cnt = 0;
        repeat (2048)
        begin
            @(posedge ref_clk);
            #1;
            if (int_o !== last)
                cnt++;
            last = int_o;
        end
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rdc(rtc_pkg::A_FLAGS, 8'h00);
        rdc(17'h00100, 8'h00);
        rtc_host_inst.put(rtc_pkg::A_TRIM, 8'h2A);
        rdc(rtc_pkg::A_TRIM, 8'h2A);
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h90);
        rdc(rtc_pkg::A_IRQ, 8'h90);
        rtc_host_inst.put(rtc_pkg::A_WDOG, 8'h82);
        repeat (4000) @(posedge ref_clk);
        pins(2'b10);
        wait_pin(1'b1, 4400);
        #1;
        pins(2'b11);
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h80);
        repeat (3) @(posedge ref_clk);
        pins(2'b10);
        check({7'h00, pin}, 8'h00);
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h10);
        repeat (3) @(posedge ref_clk);
        pins(2'b10);
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h90);
        repeat (3) @(posedge ref_clk);
        pins(2'b11);
        rdc(rtc_pkg::A_FLAGS, 8'h80);
        repeat (2) @(posedge ref_clk);
        pins(2'b10);
        rtc_host_inst.put(rtc_pkg::A_WDOG, 8'h45);
        rdc(rtc_pkg::A_WDOG, 8'h42);
        // pulse mode with a one-tick timeout
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h98);
        rtc_host_inst.put(rtc_pkg::A_WDOG, 8'h81);
        wait_pin(1'b1, 4400);
        for (n = 0; n < 100 && int_o === 1'b1; n++)
        begin
            @(posedge ref_clk);
            #1;
        end
        check({7'h00, n >= PULSE - 1 && n <= PULSE + 1}, 8'h01);
        rdc(rtc_pkg::A_FLAGS, 8'h80);
        wait_pin(1'b1, 4400);
        repeat (3) @(posedge ref_clk);
        rdc(rtc_pkg::A_FLAGS, 8'h80);
        repeat (2) @(posedge ref_clk);
        pins(2'b10);
        rtc_host_inst.put(rtc_pkg::A_WDOG, 8'h00);
        rtc_host_inst.put(rtc_pkg::A_WDOG, 8'h80);
        rdc(rtc_pkg::A_FLAGS, 8'h00);
        repeat (9000) @(posedge ref_clk);
        rdc(rtc_pkg::A_FLAGS, 8'h00);
        // alarm on seconds only, staged under write-hold
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h50);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h02);
        for (n = 3; n < 6; n++)
            rtc_host_inst.put(rtc_pkg::A_ALM_LO + 17'(n - 1), 8'h80);
        rtc_host_inst.put(rtc_pkg::A_ALM_SEC, 8'h05);
        rdc(rtc_pkg::A_ALM_SEC, 8'h05);
        @(posedge ref_clk);
        cur_seconds <= 8'h05;
        repeat (5) @(posedge ref_clk);
        rdc(rtc_pkg::A_FLAGS, 8'h02);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h00);
        cur_seconds <= 8'h06;
        @(posedge ref_clk);
        cur_seconds <= 8'h05;
        wait_pin(1'b1, 20);
        rdc(rtc_pkg::A_FLAGS, 8'h40);
        // backup supply blocks access and interrupts
        @(posedge ref_clk);
        vcc_low <= 1'b1;
        repeat (6) @(posedge ref_clk);
        pins(2'b00);
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h00);
        rdc(rtc_pkg::A_IRQ, 8'h00);
        @(posedge ref_clk);
        vcc_low <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rdc(rtc_pkg::A_IRQ, 8'h50);
        rdc(rtc_pkg::A_FLAGS, 8'h20);
        // oscillator-fail survives a flags read, cleared by a held write
        @(posedge ref_clk);
        osc_fail <= 1'b1;
        repeat (4) @(posedge ref_clk);
        osc_fail <= 1'b0;
        rdc(rtc_pkg::A_FLAGS, 8'h10);
        rdc(rtc_pkg::A_FLAGS, 8'h10);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h02);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h00);
        rdc(rtc_pkg::A_FLAGS, 8'h00);
        // trim test output at 512 Hz, independent of trim value
        rtc_host_inst.put(rtc_pkg::A_IRQ, 8'h10);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h02);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h06);
        rtc_host_inst.put(rtc_pkg::A_FLAGS, 8'h04);
        toggles(n);
        check({7'h00, n >= 15 && n <= 17}, 8'h01);
        rtc_host_inst.put(rtc_pkg::A_TRIM, 8'h1F);
        toggles(n);
        check({7'h00, n >= 15 && n <= 17}, 8'h01);
        conclude();
    end
endmodule
